// ===== logic/bpwl_word_loader.sv
// Purpose: Decodes programming words into four parameter blocks
// Assumes: 50 MHz clock; host holds word and pulses wrStrobe on the same clock
// Notes: Write-only register at the programming offset; ready flag shows busy
// Behaviour
// - Bit 15 set marks first word of a block and restarts the index.
// - Bits 14..12 select block 0, 1, 2, reserved, or block 4.
// - Block 0 bytes form frame and data patterns; inverted pattern is complement.
// - Pattern compare starts with high byte bit 7 as earliest bit.
// - Defaults C4D7 and B433 load at power-on, and on processing enable unless the save bit is set.
// - Block 1 word 0 bits 11..1 tone level; host keeps it at most 1536.
// - De-emphasis only when bit set, voice and emphasis enabled.
// - Block 1 word 1 holds threshold bits 9..4 and bandwidth bits 3..0.
// - Block 1 words 2..17 each hold one programmable tone.
// - Block 2 word 0 holds the 12-bit sub-audio level.
// - Block 2 word 1 bit 11 picks 24-bit or 23-bit squelch codes.
// - Block 2 word 1 holds threshold bits 9..4 and bandwidth bits 3..0.
// - Block 2 words 2 and 3 hold the squelch code, LSB first.
// - Code bit 23 is ignored unless 24-bit length is selected.
// - Block 2 word 4 bits 11..8 give dropout count of 8 ms steps.
// - De-response time is dropout time plus about 90 ms.
// - Block 4 word 0 is the input gain value.
// - Block 4 words 2 and 3 are output fine gains.
// - Block 4 words 4 and 5 are offsets subtracted from outputs a and b.
// - Block 4 word 6 holds ramp codes; ramps start on transmit mode edges.
// - Block 4 word 7 is limiter, reset to 1FFF.
// - Ready flag clears on a write and returns once the word is applied.
`timescale 1ns/1ps
`include "bpwl_regs.svh"
module bpwl_word_loader #(
    parameter int APPLY_CYC = `BPWL_APPLY_CYC,
    parameter int DROP_STEP_CYC = `BPWL_DROP_STEP_CYC,
    parameter int DERESP_EXTRA_CYC = `BPWL_DERESP_EXTRA_CYC,
    parameter int RAMP_STEP_CYC = `BPWL_RAMP_STEP_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic wrStrobe,
    input wire logic powerOnReset,
    input wire logic procEnable,
    input wire logic saveBit,
    input wire logic voiceEnable,
    input wire logic emphEnable,
    input wire logic txModePin,
    input wire logic rxBit,
    input wire logic rxBitValid,
    input wire logic subDetectRaw,
    output logic progReady,
    output bpwl_pkg::bpwl_modem_t modemCfg,
    output bpwl_pkg::bpwl_tone_t toneCfg,
    output bpwl_pkg::bpwl_sub_t subCfg,
    output bpwl_pkg::bpwl_gain_t gainCfg,
    output logic toneDeemphActive,
    output logic [1:0] patternHit,
    output logic subLost,
    output logic [1:0] rampState
);
    // Elaboration check: a count below one cycle would never let a timer finish
    if (APPLY_CYC < 1 || DROP_STEP_CYC < 1 || DERESP_EXTRA_CYC < 1 || RAMP_STEP_CYC < 1) begin
        $error("bpwl_word_loader: counts must be at least one cycle");
    end

    typedef struct packed {
        bpwl_pkg::bpwl_modem_t modem;
        bpwl_pkg::bpwl_tone_t tone;
        bpwl_pkg::bpwl_sub_t sub;
        bpwl_pkg::bpwl_gain_t gain;
        bpwl_pkg::bpwl_blk_t blk;
        logic [4:0] index;
        logic ready;
        logic [31:0] busyCnt;
        logic procSeen;
        logic [15:0] shiftReg;
        logic [1:0] hit;
        logic [31:0] lostCnt;
        logic lost;
        logic txPrev;
        logic [1:0] ramp;
        logic [31:0] rampCnt;
        logic deemph;
    } bpwl_state_t;

    bpwl_state_t st;
    bpwl_state_t next_st;
    logic txMode;
    logic subDetect;

    bpwl_sync3 txSync (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .pinIn(txModePin),
        .level(txMode)
    );

    bpwl_sync3 subSync (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .pinIn(subDetectRaw),
        .level(subDetect)
    );

    always_comb begin
        logic [2:0] sel;
        logic [4:0] idx;
        logic [11:0] d12;
        logic [13:0] d14;
        logic [3:0] toneSlot;
        logic [31:0] dropLimit;
        logic [31:0] rampLimit;
        bpwl_pkg::bpwl_blk_t selBlk;
        next_st = st;
        sel = regWrData[`BPWL_SEL_HI:`BPWL_SEL_LO];
        d12 = regWrData[11:0];
        d14 = regWrData[13:0];
        idx = st.index;
        toneSlot = 4'h0;
        dropLimit = 32'(st.sub.dropoutCount) * 32'(DROP_STEP_CYC) + 32'(DERESP_EXTRA_CYC);
        rampLimit = 32'(RAMP_STEP_CYC);
        selBlk = bpwl_pkg::BLK_NONE;

        // Block named by the select field; pattern 111 leaves BLK_NONE
        if (!sel[2]) begin
            selBlk = bpwl_pkg::BLK_GAIN;
        end else if (sel == `BPWL_SEL_BLK0) begin
            selBlk = bpwl_pkg::BLK_MODEM;
        end else if (sel == `BPWL_SEL_BLK1) begin
            selBlk = bpwl_pkg::BLK_TONE;
        end else if (sel == `BPWL_SEL_BLK2) begin
            selBlk = bpwl_pkg::BLK_SUB;
        end

        // Pattern defaults load at power-on or when processing comes out of reset unsaved; the limit default loads only at power-on
        if (powerOnReset || (procEnable && !st.procSeen && !saveBit)) begin
            next_st.modem.framePattern = `BPWL_FRAME_PATTERN_RST;
            next_st.modem.dataFramePattern = `BPWL_DATA_PATTERN_RST;
        end
        if (powerOnReset) begin
            next_st.gain.limitLevel = `BPWL_LIMIT_RST;
        end
        next_st.procSeen = procEnable;

        if (!st.ready) begin
            if (st.busyCnt >= 32'(APPLY_CYC - 1)) begin
                next_st.ready = 1'b1;
            end else begin
                next_st.busyCnt = st.busyCnt + 32'h1;
            end
        end

        if (wrStrobe && regAddr == `BPWL_PROG_WORD_OFFSET) begin
            next_st.ready = 1'b0;
            // A write while busy restarts the apply time
            next_st.busyCnt = 32'h0;
            if (regWrData[`BPWL_FIRST_BIT]) begin
                idx = 5'h00;
                next_st.blk = selBlk;
            end else begin
                // Index saturates so a runaway host never wraps into a valid word
                idx = (st.index == 5'h1F) ? 5'h1F : st.index + 5'h01;
                // A follow-on word whose select disagrees with the open block is dropped,
                // and so are the later words of that block
                if (selBlk != st.blk) begin
                    next_st.blk = bpwl_pkg::BLK_NONE;
                end
            end
            next_st.index = idx;
            toneSlot = 4'(idx - `BPWL_BLK1_TONE_FIRST);
            case (next_st.blk)
                bpwl_pkg::BLK_MODEM: begin
                    case (idx)
                        5'h00: next_st.modem.framePattern[7:0] = d12[7:0];
                        5'h01: next_st.modem.framePattern[15:8] = d12[7:0];
                        5'h02: next_st.modem.dataFramePattern[7:0] = d12[7:0];
                        5'h03: next_st.modem.dataFramePattern[15:8] = d12[7:0];
                        default: ;
                    endcase
                end
                bpwl_pkg::BLK_TONE: begin
                    if (idx == 5'h00) begin
                        next_st.tone.toneTxLevel = d12[11:1];
                        next_st.tone.deemphEnable = d12[`BPWL_DEEMPH_BIT];
                    end else if (idx == 5'h01) begin
                        next_st.tone.detectThreshold = d12[9:4];
                        next_st.tone.bandwidthCode = d12[3:0];
                    end else if (idx >= `BPWL_BLK1_TONE_FIRST && idx <= `BPWL_BLK1_TONE_LAST) begin
                        next_st.tone.toneInt[toneSlot] = d12[11:4];
                        next_st.tone.toneRem[toneSlot] = d12[3:0];
                    end
                end
                bpwl_pkg::BLK_SUB: begin
                    case (idx)
                        5'h00: next_st.sub.subTxLevel = d12;
                        5'h01: begin
                            next_st.sub.squelch_code_length_sel = d12[`BPWL_LEN24_BIT];
                            next_st.sub.subThreshold = d12[9:4];
                            next_st.sub.subBandwidth = d12[3:0];
                        end
                        5'h02: next_st.sub.squelchCode[11:0] = d12;
                        5'h03: next_st.sub.squelchCode[23:12] = d12;
                        5'h04: next_st.sub.dropoutCount = d12[11:8];
                        default: ;
                    endcase
                end
                bpwl_pkg::BLK_GAIN: begin
                    case (idx)
                        5'h00: next_st.gain.input_gain_value = d14;
                        5'h02: next_st.gain.output_gain_value_a = d14;
                        5'h03: next_st.gain.output_gain_value_b = d14;
                        5'h04: next_st.gain.offsetA = d14;
                        5'h05: next_st.gain.offsetB = d14;
                        5'h06: begin
                            next_st.gain.ramp_up_code = d14[13:7];
                            next_st.gain.ramp_down_code = d14[6:0];
                        end
                        5'h07: next_st.gain.limitLevel = d14;
                        default: ; // reserved word 1 and test word 8
                    endcase
                end
                default: ;
            endcase
        end

        next_st.modem.invertedFramePattern = ~next_st.modem.framePattern;
        next_st.deemph = st.tone.deemphEnable && voiceEnable && emphEnable;

        // Earliest bit ends up in bit 15, matching high byte bit 7
        next_st.hit = 2'b00;
        if (rxBitValid) begin
            next_st.shiftReg = {st.shiftReg[14:0], rxBit};
            next_st.hit[0] = (next_st.shiftReg == st.modem.framePattern) ||
                (next_st.shiftReg == st.modem.invertedFramePattern);
            next_st.hit[1] = next_st.shiftReg == st.modem.dataFramePattern;
        end

        // Loss declared only after the whole dropout plus de-response window
        if (subDetect) begin
            next_st.lostCnt = 32'h0;
            next_st.lost = 1'b0;
        end else if (st.lostCnt >= dropLimit) begin
            next_st.lost = 1'b1;
        end else begin
            next_st.lostCnt = st.lostCnt + 32'h1;
        end

        // Ramp bit 1 = ramping up, bit 0 = ramping down
        next_st.txPrev = txMode;
        if (txMode && !st.txPrev) begin
            next_st.ramp = 2'b10;
            next_st.rampCnt = 32'h0;
        end else if (!txMode && st.txPrev) begin
            next_st.ramp = 2'b01;
            next_st.rampCnt = 32'h0;
        end else if (st.ramp != 2'b00) begin
            rampLimit = (st.ramp[1] ? 32'(st.gain.ramp_up_code) : 32'(st.gain.ramp_down_code))
                + 32'h1;
            if (st.rampCnt >= rampLimit * 32'(RAMP_STEP_CYC) - 32'h1) begin
                next_st.ramp = 2'b00;
            end else begin
                next_st.rampCnt = st.rampCnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.modem.framePattern <= `BPWL_FRAME_PATTERN_RST;
            st.modem.invertedFramePattern <= ~`BPWL_FRAME_PATTERN_RST;
            st.modem.dataFramePattern <= `BPWL_DATA_PATTERN_RST;
            st.gain.limitLevel <= `BPWL_LIMIT_RST;
            st.ready <= 1'b1;
            st.blk <= bpwl_pkg::BLK_NONE;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // Squelch code bit 23 masked for 23-bit codes
    always_comb begin
        subCfg = st.sub;
        subCfg.squelchCode[23] = st.sub.squelchCode[23] & st.sub.squelch_code_length_sel;
    end

    assign progReady = st.ready;
    assign modemCfg = st.modem;
    assign toneCfg = st.tone;
    assign gainCfg = st.gain;
    assign toneDeemphActive = st.deemph;
    assign patternHit = st.hit;
    assign subLost = st.lost;
    assign rampState = st.ramp;
endmodule

// ===== logic/bpwl_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the word loader
// Assumes: 50 MHz clock
// Notes: Included by the loader files only
`ifndef BPWL_REGS_SVH
`define BPWL_REGS_SVH
`define BPWL_PROG_WORD_OFFSET 8'hC8
`define BPWL_FIRST_BIT 15
`define BPWL_SEL_HI 14
`define BPWL_SEL_LO 12
`define BPWL_SEL_BLK0 3'h4
`define BPWL_SEL_BLK1 3'h5
`define BPWL_SEL_BLK2 3'h6
`define BPWL_SEL_RSVD 3'h7
`define BPWL_BLK0_WORDS 5'h04
`define BPWL_BLK1_WORDS 5'h12
`define BPWL_BLK2_WORDS 5'h05
`define BPWL_BLK4_WORDS 5'h08
`define BPWL_BLK1_TONE_FIRST 5'h02
`define BPWL_BLK1_TONE_LAST 5'h11
`define BPWL_FRAME_PATTERN_RST 16'hC4D7
`define BPWL_DATA_PATTERN_RST 16'hB433
`define BPWL_LIMIT_RST 14'h1FFF
`define BPWL_TONE_LEVEL_MAX 11'h600
`define BPWL_DEEMPH_BIT 0
`define BPWL_LEN24_BIT 11
`define BPWL_DROP_STEP_US 8000
`define BPWL_DERESP_EXTRA_US 90000
`define BPWL_RAMP_STEP_NS 1333000
`define BPWL_CLK_NS 20
`define BPWL_APPLY_US 250
`define BPWL_APPLY_CYC ((`BPWL_APPLY_US * 1000) / `BPWL_CLK_NS)
`define BPWL_DROP_STEP_CYC ((`BPWL_DROP_STEP_US * 1000) / `BPWL_CLK_NS)
`define BPWL_DERESP_EXTRA_CYC ((`BPWL_DERESP_EXTRA_US * 1000) / `BPWL_CLK_NS)
`define BPWL_RAMP_STEP_CYC (`BPWL_RAMP_STEP_NS / `BPWL_CLK_NS)
`endif

// ===== logic/bpwl_pkg.sv
// Purpose: Types of the word loader
// Assumes: Nothing
// Notes: Constants live in bpwl_regs.svh
package bpwl_pkg;
    typedef enum logic [2:0] {BLK_NONE, BLK_MODEM, BLK_TONE, BLK_SUB, BLK_GAIN} bpwl_blk_t;
    typedef struct packed {
        logic [15:0] framePattern;
        logic [15:0] invertedFramePattern;
        logic [15:0] dataFramePattern;
    } bpwl_modem_t;
    typedef struct packed {
        logic [10:0] toneTxLevel;
        logic deemphEnable;
        logic [5:0] detectThreshold;
        logic [3:0] bandwidthCode;
        logic [15:0][7:0] toneInt;
        logic [15:0][3:0] toneRem;
    } bpwl_tone_t;
    typedef struct packed {
        logic [11:0] subTxLevel;
        logic squelch_code_length_sel;
        logic [5:0] subThreshold;
        logic [3:0] subBandwidth;
        logic [23:0] squelchCode;
        logic [3:0] dropoutCount;
    } bpwl_sub_t;
    typedef struct packed {
        logic [13:0] input_gain_value;
        logic [13:0] output_gain_value_a;
        logic [13:0] output_gain_value_b;
        logic [13:0] offsetA;
        logic [13:0] offsetB;
        logic [6:0] ramp_up_code;
        logic [6:0] ramp_down_code;
        logic [13:0] limitLevel;
    } bpwl_gain_t;
endpackage

// ===== logic/bpwl_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin level
// Assumes: Input asynchronous to clock
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module bpwl_sync3 (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic pinIn,
    output logic level
);
    logic [2:0] stage;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else if (clkEn) begin
            stage <= {stage[1:0], pinIn};
            if (stage[1] == stage[2]) begin
                level <= stage[2];
            end
        end
    end
endmodule

// ===== verif/bpwl_word_loader_sva.sv
// Purpose: Port checks of the word loader
// Assumes: clkEn held high by the bench
// Notes: Bound to every loader instance
`timescale 1ns/1ps
module bpwl_word_loader_sva #(
    parameter int APPLY_CYC = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic wrStrobe,
    input wire logic voiceEnable,
    input wire logic emphEnable,
    input wire logic progReady,
    input wire bpwl_pkg::bpwl_modem_t modemCfg,
    input wire bpwl_pkg::bpwl_tone_t toneCfg,
    input wire bpwl_pkg::bpwl_sub_t subCfg,
    input wire bpwl_pkg::bpwl_gain_t gainCfg,
    input wire logic toneDeemphActive
);
    logic wr;
    int busyCnt;
    assign wr = clkEn && wrStrobe && regAddr == 8'hC8;
    // Busy span counted, a long repetition would slow the tools
    always_ff @(posedge clock) begin
        if (!rst_n || progReady) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= busyCnt + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ready_drop_a: assert property (wr |=> !progReady)
        else $error("ready flag not cleared by a write");
    busy_bound_a: assert property (busyCnt <= APPLY_CYC)
        else $error("ready flag low too long");
    inv_pattern_a: assert property (modemCfg.invertedFramePattern == ~modemCfg.framePattern)
        else $error("inverted pattern not complement");
    reset_defaults_a: assert property ($rose(rst_n) |-> modemCfg.framePattern == 16'hC4D7
        && modemCfg.dataFramePattern == 16'hB433 && gainCfg.limitLevel == 14'h1FFF)
        else $error("wrong values after reset");
    frame_low_a: assert property (wr && regWrData[15:12] == 4'hC
        |=> modemCfg.framePattern[7:0] == $past(regWrData[7:0]))
        else $error("frame low byte not loaded");
    gain_load_a: assert property (wr && regWrData[15:14] == 2'b10
        |=> gainCfg.input_gain_value == $past(regWrData[13:0]))
        else $error("input gain not loaded");
    rsvd_hold_a: assert property (wr && regWrData[14:12] == 3'h7
        |=> $stable({modemCfg, toneCfg, subCfg, gainCfg}))
        else $error("reserved select changed a field");
    code_mask_a: assert property (!subCfg.squelch_code_length_sel |-> !subCfg.squelchCode[23])
        else $error("code bit 23 seen with short length");
    deemph_gate_a: assert property (toneDeemphActive == ($past(toneCfg.deemphEnable)
        && $past(voiceEnable) && $past(emphEnable)))
        else $error("de-emphasis differs from the gated enables");
    cover property (wr && regWrData[15:12] == 4'hC);
    cover property ($rose(progReady));
    cover property (toneDeemphActive);
endmodule
bind bpwl_word_loader bpwl_word_loader_sva #(.APPLY_CYC(APPLY_CYC)) chk_u (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .wrStrobe(wrStrobe), .voiceEnable(voiceEnable), .emphEnable(emphEnable),
    .progReady(progReady), .modemCfg(modemCfg), .toneCfg(toneCfg), .subCfg(subCfg),
    .gainCfg(gainCfg), .toneDeemphActive(toneDeemphActive));

// ===== verif/bpwl_host_model.sv
// Purpose: Host side that writes programming words
// Assumes: send is called just after a falling edge
// Notes: Released lines show the inverse, never the stale word
`timescale 1ns/1ps
module bpwl_host_model (
    input wire logic clock,
    input wire logic progReady,
    output logic [7:0] regAddr,
    output logic [15:0] regWrData,
    output logic wrStrobe
);
    initial begin
        regAddr = 8'h37;
        regWrData = 16'hFFFF;
        wrStrobe = 1'b0;
    end
    task automatic send(input logic [7:0] addr, input logic [15:0] word);
        // Never writes while the device is still applying a word; one edge between strobes
        do begin
            @(negedge clock);
        end while (progReady !== 1'b1);
        regAddr = addr;
        regWrData = word;
        wrStrobe = 1'b1;
        @(negedge clock);
        wrStrobe = 1'b0;
        regAddr = ~addr;
        regWrData = ~word;
    endtask
endmodule

// ===== verif/test_block_programming_word_loader.sv
// Purpose: Self-checking bench of the word loader
// Assumes: Shortened apply and timing parameters
// Notes: Host model issues every programming word
`timescale 1ns/1ps
module test_block_programming_word_loader;
    logic clock = 0;
    logic rst_n = 0;
    logic powerOnReset = 0;
    logic procEnable = 0;
    logic saveBit = 0;
    logic voiceEnable = 0;
    logic emphEnable = 0;
    logic txModePin = 0;
    logic rxBit = 0;
    logic rxBitValid = 0;
    logic subDetectRaw = 1;
    logic progReady, toneDeemphActive, subLost, wrStrobe;
    logic [1:0] patternHit, rampState;
    logic [7:0] regAddr;
    logic [15:0] regWrData;
    bpwl_pkg::bpwl_modem_t modemCfg;
    bpwl_pkg::bpwl_tone_t toneCfg;
    bpwl_pkg::bpwl_sub_t subCfg;
    bpwl_pkg::bpwl_gain_t gainCfg;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'hE5DAE51A;
    always #10 clock = ~clock;
    bpwl_word_loader #(.APPLY_CYC(4), .DROP_STEP_CYC(4), .DERESP_EXTRA_CYC(8),
        .RAMP_STEP_CYC(4)) dut_u (
        .clock(clock), .rst_n(rst_n), .clkEn(1'b1), .regAddr(regAddr),
        .regWrData(regWrData), .wrStrobe(wrStrobe), .powerOnReset(powerOnReset),
        .procEnable(procEnable), .saveBit(saveBit), .voiceEnable(voiceEnable),
        .emphEnable(emphEnable), .txModePin(txModePin), .rxBit(rxBit),
        .rxBitValid(rxBitValid), .subDetectRaw(subDetectRaw), .progReady(progReady),
        .modemCfg(modemCfg), .toneCfg(toneCfg), .subCfg(subCfg), .gainCfg(gainCfg),
        .toneDeemphActive(toneDeemphActive), .patternHit(patternHit),
        .subLost(subLost), .rampState(rampState));
    bpwl_host_model host_u (.clock(clock), .progReady(progReady), .regAddr(regAddr),
        .regWrData(regWrData), .wrStrobe(wrStrobe));
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [15:0] w);
        host_u.send(8'hC8, w);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Tone word from a frequency: integer and rounded remainder
    function automatic logic [11:0] tone_word(input int f);
        real x;
        x = 0.042666 * f;
        tone_word[11:4] = 8'($rtoi(x));
        tone_word[3:0] = 4'($rtoi((x - $rtoi(x)) * 6000.0 / f + 0.5));
    endfunction
    initial begin
        #(20 * 6000);
        n_mismatch++;
        test_done();
    end
    initial begin
        logic [15:0] fp, dp, w;
        logic [10:0] lvl;
        logic [23:0] c;
        logic [11:0] tw [16];
        logic [13:0] g [8];
        repeat (8) @(negedge clock);
        rst_n = 1;
        procEnable = 1;
        @(negedge clock);
        chk(modemCfg, {16'hC4D7, 16'h3B28, 16'hB433});
        chk({progReady, gainCfg.limitLevel}, {1'b1, 14'h1FFF});
        fp = $random(seed);
        dp = $random(seed);
        put({8'hC0, fp[7:0]});
        put({8'h40, fp[15:8]});
        put({8'h40, dp[7:0]});
        put({8'h40, dp[15:8]});
        put(16'h405A);
        chk(progReady, 1'b0);
        host_u.send(8'hC9, 16'hC0AA);
        put(16'hF123);
        chk(modemCfg, {fp, ~fp, dp});
        // Frame pattern then data pattern, earliest bit first
        for (int i = 31; i >= 0; i--) begin
            rxBit = (i > 15) ? fp[i - 16] : dp[i];
            rxBitValid = 1;
            @(negedge clock);
            if (i == 16) begin
                chk(patternHit[0], 1'b1);
            end
        end
        rxBitValid = 0;
        chk(patternHit[1], 1'b1);
        lvl = 11'({$random(seed)} % 1537);
        w = $random(seed);
        put({4'hD, lvl, 1'b1});
        put({6'h14, w[9:4], 2'b10, w[1:0]});
        for (int i = 0; i < 16; i++) begin
            tw[i] = tone_word(400 + {$random(seed)} % 2601);
            put({4'h5, tw[i]});
        end
        put(16'h5ABC);
        chk({toneCfg.toneTxLevel, toneCfg.deemphEnable, toneCfg.detectThreshold,
            toneCfg.bandwidthCode}, {lvl, 1'b1, w[9:4], 2'b10, w[1:0]});
        for (int i = 0; i < 16; i++) begin
            chk({toneCfg.toneInt[i], toneCfg.toneRem[i]}, tw[i]);
        end
        for (int k = 0; k < 4; k++) begin
            {voiceEnable, emphEnable} = 2'(k);
            repeat (2) @(negedge clock);
            chk(toneDeemphActive, k == 3);
        end
        c = $random(seed) | 24'h800000;
        w = $random(seed);
        put({4'hE, w[11:0]});
        put({6'h18, w[9:4], 4'h6});
        put({4'h6, c[11:0]});
        put({4'h6, c[23:12]});
        put(16'h6F00);
        chk(subCfg, {w[11:0], 1'b0, w[9:4], 4'h6, 1'b0, c[22:0], 4'hF});
        put({4'hE, w[11:0]});
        put({6'h1A, w[9:4], 4'h6});
        chk(subCfg.squelchCode, c);
        subDetectRaw = 0;
        repeat (50) @(negedge clock);
        chk(subLost, 1'b0);
        repeat (30) @(negedge clock);
        chk(subLost, 1'b1);
        for (int i = 0; i < 8; i++) begin
            g[i] = $random(seed);
        end
        g[6] = g[6] | 14'h2040;
        put({2'b10, g[0]});
        for (int i = 1; i < 8; i++) begin
            put({2'b00, g[i]});
        end
        chk(gainCfg, {g[0], g[2], g[3], g[4], g[5], g[6], g[7]});
        txModePin = 1;
        repeat (8) @(negedge clock);
        chk(rampState, 2'b10);
        repeat ((1 + g[6][13:7]) * 4 + 4) @(negedge clock);
        chk(rampState, 2'b00);
        txModePin = 0;
        repeat (8) @(negedge clock);
        chk(rampState, 2'b01);
        saveBit = 1;
        procEnable = 0;
        repeat (2) @(negedge clock);
        procEnable = 1;
        repeat (2) @(negedge clock);
        chk(modemCfg.framePattern, fp);
        powerOnReset = 1;
        repeat (2) @(negedge clock);
        powerOnReset = 0;
        @(negedge clock);
        chk({modemCfg.framePattern, gainCfg.limitLevel}, {16'hC4D7, 14'h1FFF});
        put({8'hC0, dp[7:0]});
        put(16'h5012);
        chk(modemCfg.framePattern, {8'hC4, dp[7:0]});
        saveBit = 0;
        procEnable = 0;
        repeat (2) @(negedge clock);
        procEnable = 1;
        repeat (2) @(negedge clock);
        chk({modemCfg.framePattern, modemCfg.dataFramePattern}, {16'hC4D7, 16'hB433});
        test_done();
    end
endmodule
